// ### crsl_pkg.sv
// Purpose: shared constants and types of the card response and state logic
// Assumes: commands arrive already decoded, one per cycle, on the system clock
// Notes: response frames are left aligned in a 136 bit vector, msb sent first
package crsl_pkg;
    // ==========================================================================
    // command indexes
    localparam logic [5:0] CMD_GO_IDLE = 6'h00;
    localparam logic [5:0] CMD_ALL_ID = 6'h02;
    localparam logic [5:0] CMD_PUB_ADDR = 6'h03;
    localparam logic [5:0] CMD_SELECT = 6'h07;
    localparam logic [5:0] CMD_SEND_SPEC = 6'h09;
    localparam logic [5:0] CMD_SEND_ID = 6'h0a;
    localparam logic [5:0] CMD_STOP = 6'h0c;
    localparam logic [5:0] CMD_STATUS = 6'h0d;
    localparam logic [5:0] CMD_GO_INACT = 6'h0f;
    localparam logic [5:0] CMD_ERASE_START = 6'h20;
    localparam logic [5:0] CMD_ERASE_END = 6'h21;
    localparam logic [5:0] CMD_ERASE = 6'h26;
    localparam logic [5:0] CMD_LOCK = 6'h2a;
    localparam logic [5:0] CMD_APP_PREFIX = 6'h37;
    localparam logic [5:0] CMD_GEN = 6'h38;
    localparam logic [5:0] ACMD_BUS_WIDTH = 6'h06;
    localparam logic [5:0] ACMD_STATUS = 6'h0d;
    localparam logic [5:0] ACMD_WR_COUNT = 6'h16;
    localparam logic [5:0] ACMD_PRE_ERASE = 6'h17;
    localparam logic [5:0] ACMD_OP_COND = 6'h29;
    localparam logic [5:0] ACMD_DETECT = 6'h2a;
    localparam logic [5:0] ACMD_CONFIG = 6'h33;
    // ==========================================================================
    // frame fields
    localparam logic [7:0] LEN_SHORT = 8'h30;
    localparam logic [7:0] LEN_LONG = 8'h88;
    localparam int FRAME_W = 136;
    localparam logic [5:0] FIELD_ONES6 = 6'h3f;
    localparam logic [6:0] FIELD_ONES7 = 7'h7f;
    localparam logic [6:0] CRC7_POLY = 7'h09;
    localparam int ST_BIT_A = 23;
    localparam int ST_BIT_B = 22;
    localparam int ST_BIT_C = 19;
    // ==========================================================================
    // types
    typedef enum logic [9:0] {
        ST_IDLE = 10'h001, ST_READY = 10'h002, ST_IDENT = 10'h004, ST_STBY = 10'h008,
        ST_TRAN = 10'h010, ST_DATA = 10'h020, ST_RCV = 10'h040, ST_PRG = 10'h080,
        ST_DIS = 10'h100, ST_INA = 10'h200
    } crsl_state_t;
    // no fourth or fifth response type exists here
    typedef enum logic [2:0] {
        RT_NONE = 3'h0, RT_STD = 3'h1, RT_BUSY = 3'h2, RT_REG = 3'h3, RT_OCR = 3'h4,
        RT_ADDR = 3'h5
    } crsl_rtype_t;
    typedef struct packed {
        logic [5:0] idx;
        logic rd;
        logic vdd_ok;
        logic pwr_busy;
        logic addressed;
    } crsl_cmd_t;
    typedef struct packed {
        logic [127:0] cid;
        logic [127:0] csd;
        logic [31:0] ocr;
        logic [31:0] status;
        logic [15:0] rca;
    } crsl_card_t;
    typedef struct packed {
        crsl_rtype_t rt;
        logic [7:0] len;
        logic [FRAME_W-1:0] bits;
    } crsl_frame_t;
endpackage

// ### crsl_core.sv
// Purpose: card state machine for decoded commands and serial response framing
// Assumes: card_clk_i is the host bus clock and runs while a response is due
// Notes: frames cross to the bus clock by a toggle handshake; words stay stable
//
// Overview of operation
// [R01] responses go out serially on the command line, msb first, length by type
// [R02] frame opens with start 0 and direction 0, closes with end bit 1
// [R03] every response carries a checksum except the operating-condition one
// [R04] standard response: 48 bits, index 45:40, status 39:8, crc 7:1
// [R05] card may hold data line busy after written blocks; host checks each block
// [R06] busy-variant commands may hold data line busy; host checks from response
// [R07] register response: 136 bits, bits 133:128 all ones, 127:1 register content
// [R08] identification register for cmd2 and cmd10, specific data for cmd9
// [R09] register bit 0 is not sent; the end bit takes its place
// [R10] operating-condition response: 48 bits, register 39:8, index and crc all ones
// [R11] fourth and fifth response types are never generated
// [R12] address response: index 3, new address 31:16, status 23,22,19,12:0
// [R13] operating-condition command in idle, voltage compatible: go ready
// [R14] operating-condition command in idle while powering up: stay idle
// [R15] operating-condition command in idle, voltage incompatible: go inactive
// [R16] optional class 7 lock command is supported
// [R17] erase start and end keep transfer; erase goes to programming
// [R18] app prefix keeps state; general command goes receive or sending-data
// [R19] transfer-state app commands keep transfer; configuration read goes data
module crsl_core (
    // system side
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // decoded command
    input wire logic cmd_vld_i,
    output logic cmd_rdy_o,
    input wire crsl_pkg::crsl_cmd_t cmd_i,
    input wire crsl_pkg::crsl_card_t card_i,
    // transfer events and state outputs
    input wire logic xfer_done_i,
    input wire logic prg_done_i,
    output crsl_pkg::crsl_state_t state_o,
    output logic app_o,
    // card bus
    input wire logic card_clk_i,
    output logic cmd_o,
    output logic cmd_oe_o,
    output logic dat0_o,
    output logic dat0_oe_o
);
    // ==========================================================================
    // helpers
    function automatic logic [6:0] crc7(input logic [39:0] d);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int i = 39; i >= 0; i--) begin
            fb = d[i] ^ c[6];
            c = {c[5:0], 1'b0} ^ (fb ? crsl_pkg::CRC7_POLY : 7'h00);
        end
        return c;
    endfunction

    function automatic logic [135:0] short_frame(input logic [5:0] idx,
                                                 input logic [31:0] pay, input logic [6:0] crc);
        return {2'b00, idx, pay, crc, 1'b1, 88'h0}; // [R01] [R02]
    endfunction

    // ==========================================================================
    // state machine
    crsl_pkg::crsl_state_t state_q, state_d;
    crsl_pkg::crsl_rtype_t rt_d;
    crsl_pkg::crsl_frame_t frame_q, frame_d;
    logic app_q, app_d;
    logic pend_q, req_q;
    logic ack_meta_q, ack_sync_q, ack_seen_q;
    logic accept;
    logic [39:0] head;
    logic [15:0] short_st;

    assign cmd_rdy_o = !pend_q;
    assign accept = cmd_vld_i && !pend_q;
    assign state_o = state_q;
    assign app_o = app_q;

    always_comb begin
        state_d = state_q;
        rt_d = crsl_pkg::RT_NONE;
        app_d = 1'b0;
        if (app_q) begin
            unique case (cmd_i.idx)
                crsl_pkg::ACMD_OP_COND: begin
                    if (state_q == crsl_pkg::ST_IDLE) begin
                        if (!cmd_i.vdd_ok) begin
                            state_d = crsl_pkg::ST_INA; // [R15]
                        end else begin
                            rt_d = crsl_pkg::RT_OCR;
                            if (!cmd_i.pwr_busy) begin
                                state_d = crsl_pkg::ST_READY; // [R13]
                            end // [R14]
                        end
                    end
                end
                crsl_pkg::ACMD_BUS_WIDTH, crsl_pkg::ACMD_STATUS, crsl_pkg::ACMD_WR_COUNT,
                crsl_pkg::ACMD_PRE_ERASE, crsl_pkg::ACMD_DETECT: begin
                    if (state_q == crsl_pkg::ST_TRAN) rt_d = crsl_pkg::RT_STD; // [R19]
                end
                crsl_pkg::ACMD_CONFIG: begin
                    if (state_q == crsl_pkg::ST_TRAN) begin
                        rt_d = crsl_pkg::RT_STD;
                        state_d = crsl_pkg::ST_DATA; // [R19]
                    end
                end
                default: ;
            endcase
        end else begin
            unique case (cmd_i.idx)
                crsl_pkg::CMD_GO_IDLE: begin
                    if (state_q != crsl_pkg::ST_INA) state_d = crsl_pkg::ST_IDLE;
                end
                crsl_pkg::CMD_ALL_ID: begin
                    if (state_q == crsl_pkg::ST_READY) begin
                        rt_d = crsl_pkg::RT_REG; // [R08]
                        state_d = crsl_pkg::ST_IDENT;
                    end
                end
                crsl_pkg::CMD_PUB_ADDR: begin
                    if (state_q inside {crsl_pkg::ST_IDENT, crsl_pkg::ST_STBY}) begin
                        rt_d = crsl_pkg::RT_ADDR;
                        state_d = crsl_pkg::ST_STBY;
                    end
                end
                crsl_pkg::CMD_SELECT: begin
                    if (cmd_i.addressed) begin
                        if (state_q == crsl_pkg::ST_STBY) begin
                            rt_d = crsl_pkg::RT_BUSY;
                            state_d = crsl_pkg::ST_TRAN;
                        end else if (state_q == crsl_pkg::ST_DIS) begin
                            rt_d = crsl_pkg::RT_BUSY;
                            state_d = crsl_pkg::ST_PRG;
                        end
                    end else if (state_q inside {crsl_pkg::ST_STBY, crsl_pkg::ST_TRAN,
                                                 crsl_pkg::ST_DATA}) begin
                        state_d = crsl_pkg::ST_STBY;
                    end else if (state_q == crsl_pkg::ST_PRG) begin
                        state_d = crsl_pkg::ST_DIS;
                    end
                end
                crsl_pkg::CMD_SEND_SPEC, crsl_pkg::CMD_SEND_ID: begin
                    if (state_q == crsl_pkg::ST_STBY) rt_d = crsl_pkg::RT_REG; // [R08]
                end
                crsl_pkg::CMD_STOP: begin
                    if (state_q == crsl_pkg::ST_DATA) begin
                        rt_d = crsl_pkg::RT_BUSY;
                        state_d = crsl_pkg::ST_TRAN;
                    end else if (state_q == crsl_pkg::ST_RCV) begin
                        rt_d = crsl_pkg::RT_BUSY;
                        state_d = crsl_pkg::ST_PRG;
                    end
                end
                crsl_pkg::CMD_STATUS: begin
                    if (!(state_q inside {crsl_pkg::ST_IDLE, crsl_pkg::ST_READY,
                                          crsl_pkg::ST_IDENT, crsl_pkg::ST_INA})) begin
                        rt_d = crsl_pkg::RT_STD;
                    end
                end
                crsl_pkg::CMD_GO_INACT: begin
                    if (!(state_q inside {crsl_pkg::ST_IDLE, crsl_pkg::ST_READY,
                                          crsl_pkg::ST_IDENT})) begin
                        state_d = crsl_pkg::ST_INA;
                    end
                end
                crsl_pkg::CMD_ERASE_START, crsl_pkg::CMD_ERASE_END: begin
                    if (state_q == crsl_pkg::ST_TRAN) rt_d = crsl_pkg::RT_STD; // [R17]
                end
                crsl_pkg::CMD_ERASE: begin
                    if (state_q == crsl_pkg::ST_TRAN) begin
                        rt_d = crsl_pkg::RT_BUSY;
                        state_d = crsl_pkg::ST_PRG; // [R17]
                    end
                end
                crsl_pkg::CMD_LOCK: begin
                    if (state_q == crsl_pkg::ST_TRAN) begin
                        rt_d = crsl_pkg::RT_STD;
                        state_d = crsl_pkg::ST_RCV; // [R16]
                    end
                end
                crsl_pkg::CMD_APP_PREFIX: begin
                    if (!(state_q inside {crsl_pkg::ST_READY, crsl_pkg::ST_IDENT,
                                          crsl_pkg::ST_INA})) begin
                        rt_d = crsl_pkg::RT_STD; // [R18]
                        app_d = 1'b1;
                    end
                end
                crsl_pkg::CMD_GEN: begin
                    if (state_q == crsl_pkg::ST_TRAN) begin
                        rt_d = crsl_pkg::RT_STD;
                        state_d = cmd_i.rd ? crsl_pkg::ST_DATA : crsl_pkg::ST_RCV; // [R18]
                    end
                end
                default: ;
            endcase
        end
    end

    // ==========================================================================
    // frame assembly
    assign short_st = {card_i.status[crsl_pkg::ST_BIT_A], card_i.status[crsl_pkg::ST_BIT_B],
                       card_i.status[crsl_pkg::ST_BIT_C], card_i.status[12:0]}; // [R12]

    always_comb begin
        head = 40'h0;
        frame_d.rt = rt_d;
        frame_d.len = crsl_pkg::LEN_SHORT;
        frame_d.bits = 136'h0;
        unique case (rt_d)
            crsl_pkg::RT_STD, crsl_pkg::RT_BUSY: begin
                head = {2'b00, cmd_i.idx, card_i.status};
                frame_d.bits = short_frame(cmd_i.idx, card_i.status, crc7(head)); // [R04]
            end
            crsl_pkg::RT_ADDR: begin
                head = {2'b00, crsl_pkg::CMD_PUB_ADDR, card_i.rca, short_st};
                frame_d.bits = short_frame(crsl_pkg::CMD_PUB_ADDR, {card_i.rca, short_st},
                                           crc7(head)); // [R12] [R03]
            end
            crsl_pkg::RT_OCR: begin
                // no checksum is computed for this type
                frame_d.bits = short_frame(crsl_pkg::FIELD_ONES6, card_i.ocr,
                                           crsl_pkg::FIELD_ONES7); // [R10] [R03]
            end
            crsl_pkg::RT_REG: begin
                frame_d.len = crsl_pkg::LEN_LONG; // [R07]
                frame_d.bits = {2'b00, crsl_pkg::FIELD_ONES6,
                                (cmd_i.idx == crsl_pkg::CMD_SEND_SPEC) ? card_i.csd[127:1]
                                                                       : card_i.cid[127:1],
                                1'b1}; // [R09] [R08]
            end
            default: ;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_q <= crsl_pkg::ST_IDLE;
            app_q <= 1'b0;
        end else if (accept) begin
            state_q <= state_d;
            app_q <= app_d;
        end else if (xfer_done_i && state_q == crsl_pkg::ST_DATA) begin
            state_q <= crsl_pkg::ST_TRAN;
        end else if (xfer_done_i && state_q == crsl_pkg::ST_RCV) begin
            state_q <= crsl_pkg::ST_PRG; // [R05]
        end else if (prg_done_i && state_q == crsl_pkg::ST_PRG) begin
            state_q <= crsl_pkg::ST_TRAN;
        end
    end

    // frame_q stays frozen while pend_q is high, so the bus side may sample it
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            frame_q <= '0;
            req_q <= 1'b0;
            pend_q <= 1'b0;
        end else if (accept && rt_d != crsl_pkg::RT_NONE) begin
            frame_q <= frame_d;
            req_q <= ~req_q;
            pend_q <= 1'b1;
        end else if (ack_sync_q != ack_seen_q) begin
            pend_q <= 1'b0;
        end
    end

    // ==========================================================================
    // bus clock domain
    logic lrst_meta_q, lrst_q;
    logic req_meta_q, req_sync_q, req_seen_q;
    logic bsy_meta_q, bsy_sync_q;
    logic active_q, ack_q;
    logic [7:0] cnt_q;
    logic [135:0] shift_q;

    always_ff @(posedge card_clk_i) begin
        lrst_meta_q <= srst_i;
        lrst_q <= lrst_meta_q;
        // glitch-free bit
        bsy_meta_q <= |(state_q & crsl_pkg::ST_PRG);
        bsy_sync_q <= bsy_meta_q;
    end

    always_ff @(posedge card_clk_i) begin
        if (lrst_q) begin
            req_meta_q <= 1'b0;
            req_sync_q <= 1'b0;
            req_seen_q <= 1'b0;
            active_q <= 1'b0;
            ack_q <= 1'b0;
            cnt_q <= 8'h00;
            shift_q <= 136'h0;
        end else begin
            req_meta_q <= req_q;
            req_sync_q <= req_meta_q;
            if (!active_q && req_sync_q != req_seen_q) begin
                req_seen_q <= req_sync_q;
                active_q <= 1'b1;
                shift_q <= frame_q.bits;
                cnt_q <= frame_q.len;
            end else if (active_q) begin
                shift_q <= {shift_q[134:0], 1'b0}; // [R01]
                cnt_q <= cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    active_q <= 1'b0;
                    ack_q <= ~ack_q;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ack_meta_q <= 1'b0;
            ack_sync_q <= 1'b0;
            ack_seen_q <= 1'b0;
        end else begin
            ack_meta_q <= ack_q;
            ack_sync_q <= ack_meta_q;
            ack_seen_q <= ack_sync_q;
        end
    end

    assign cmd_o = active_q ? shift_q[135] : 1'b1;
    assign cmd_oe_o = active_q;
    // busy shows as a held low on data line 0 while programming runs
    assign dat0_o = 1'b0;
    assign dat0_oe_o = bsy_sync_q; // [R05] [R06]

    // ==========================================================================
    // checks
    AST_START_DIR: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [R02]
        pend_q |-> frame_q.bits[135:134] == 2'b00) else $error("start or direction bit set");
    AST_END_BIT: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [R02]
        pend_q |-> frame_q.bits[8'(136 - int'(frame_q.len))]) else $error("end bit low");
    AST_STD_LAYOUT: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [R04]
        accept && rt_d == crsl_pkg::RT_STD |=> frame_q.len == crsl_pkg::LEN_SHORT
        && frame_q.bits[133:128] == $past(cmd_i.idx)
        && frame_q.bits[127:96] == $past(card_i.status)) else $error("standard frame wrong");
    AST_REG_LAYOUT: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [R07]
        accept && rt_d == crsl_pkg::RT_REG && cmd_i.idx == crsl_pkg::CMD_SEND_SPEC
        |=> frame_q.len == crsl_pkg::LEN_LONG && frame_q.bits[133:128] == 6'h3f
        && frame_q.bits[127:1] == $past(card_i.csd[127:1])) else $error("register frame wrong");
    AST_OCR_LAYOUT: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [R10]
        accept && rt_d == crsl_pkg::RT_OCR |=> frame_q.bits[133:128] == 6'h3f
        && frame_q.bits[95:89] == 7'h7f && frame_q.bits[127:96] == $past(card_i.ocr))
        else $error("operating-condition frame wrong");
    AST_ADDR_LAYOUT: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [R12]
        accept && rt_d == crsl_pkg::RT_ADDR |=> frame_q.bits[133:128] == 6'h03
        && frame_q.bits[127:112] == $past(card_i.rca)) else $error("address frame wrong");
    AST_OPCOND_READY: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [R13]
        accept && app_q && cmd_i.idx == crsl_pkg::ACMD_OP_COND && cmd_i.vdd_ok
        && !cmd_i.pwr_busy && state_q == crsl_pkg::ST_IDLE |=> state_q == crsl_pkg::ST_READY)
        else $error("no move to ready");
    AST_OPCOND_BUSY: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [R14]
        accept && app_q && cmd_i.idx == crsl_pkg::ACMD_OP_COND && cmd_i.vdd_ok
        && cmd_i.pwr_busy && state_q == crsl_pkg::ST_IDLE |=> state_q == crsl_pkg::ST_IDLE)
        else $error("left idle while powering up");
    AST_OPCOND_INACT: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [R15]
        accept && app_q && cmd_i.idx == crsl_pkg::ACMD_OP_COND && !cmd_i.vdd_ok
        && state_q == crsl_pkg::ST_IDLE |=> state_q == crsl_pkg::ST_INA && !pend_q)
        else $error("no move to inactive");
    AST_ERASE_PRG: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [R17]
        accept && !app_q && cmd_i.idx == crsl_pkg::CMD_ERASE && state_q == crsl_pkg::ST_TRAN
        |=> state_q == crsl_pkg::ST_PRG ##0 frame_q.rt == crsl_pkg::RT_BUSY)
        else $error("erase did not enter programming");
    AST_APP_KEEP: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [R18]
        accept && !app_q && cmd_i.idx == crsl_pkg::CMD_APP_PREFIX
        && state_q == crsl_pkg::ST_TRAN |=> app_q && state_q == crsl_pkg::ST_TRAN)
        else $error("prefix changed state");
    AST_CONFIG_DATA: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [R19]
        accept && app_q && cmd_i.idx == crsl_pkg::ACMD_CONFIG && state_q == crsl_pkg::ST_TRAN
        |=> state_q == crsl_pkg::ST_DATA && !app_q) else $error("config read not in data");
    AST_LINK_HEAD: assert property (@(posedge card_clk_i) disable iff (lrst_q) // [R01]
        $rose(active_q) |-> cmd_oe_o && !cmd_o ##1 cmd_oe_o && !cmd_o)
        else $error("frame head not zero zero");
    COV_STD: cover property (@(posedge sys_clk_i) accept && rt_d == crsl_pkg::RT_STD);
    COV_REG: cover property (@(posedge sys_clk_i) accept && rt_d == crsl_pkg::RT_REG);
    COV_OCR: cover property (@(posedge sys_clk_i) accept && rt_d == crsl_pkg::RT_OCR);
    COV_SENT: cover property (@(posedge card_clk_i) $fell(active_q));
endmodule

// ### crsl_host_model.sv
// Purpose: host side of the card bus: makes the bus clock and collects response bits
// Assumes: one response at a time; the bench clears the collector before each command
// Notes: the bus clock stands still at 0 while run_i is low
module crsl_host_model (
    // control from the bench
    input wire logic run_i,
    input wire logic clr_i,
    // card bus
    input wire logic cmd_o_i,
    input wire logic cmd_oe_i,
    input wire logic dat0_i,
    input wire logic dat0_oe_i,
    output logic card_clk_o,
    // what the host saw
    output logic [135:0] frame_o,
    output logic [7:0] nbits_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================================
    // bus clock, 32 ns
    initial begin
        card_clk_o = 1'b0;
        forever begin
            #16;
            card_clk_o = run_i ? ~card_clk_o : 1'b0;
        end
    end
    // ==========================================================================
    // busy sampled on the data line, pull-up when released
    assign busy_o = !(dat0_oe_i ? dat0_i : 1'b1);
    // undriven command line floats to 1 through the pull-up
    always @(posedge card_clk_o or posedge clr_i) begin
        if (clr_i) begin
            frame_o <= '0;
            nbits_o <= 8'h00;
        end else if (cmd_oe_i) begin
            frame_o <= {frame_o[134:0], cmd_o_i};
            nbits_o <= nbits_o + 8'h01;
        end
    end
endmodule

// ### tb_card_response_state_logic.sv
// Purpose: self-checking bench of the card state logic and response framing
// Assumes: every command issued here is answered on the command line, except the operating-condition command with voltage incompatible
// Notes: reset is held longer so the bus-clock side sees enough edges
module tb_card_response_state_logic;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ST = 32'h00c8_1a5b;
    logic sys_clk_i = 0, srst_i = 1, cmd_vld_i = 0, xfer_done_i = 0, prg_done_i = 0;
    logic run = 1, clr = 0, cmd_rdy_o, app_o, cmd_o, cmd_oe_o, dat0_o, dat0_oe_o, card_clk, busy;
    logic [135:0] frame;
    logic [7:0] nbits;
    int n_fail = 0, checks_done = 0;
    crsl_pkg::crsl_cmd_t cmd_i = '0;
    crsl_pkg::crsl_card_t card_i;
    crsl_pkg::crsl_state_t state_o;
    assign card_i = '{cid: {4{32'h1357_9bde}}, csd: {4{32'h2468_ace0}}, ocr: 32'h80ff_8000,
                      status: ST, rca: 16'hbeef};
    initial forever #4 sys_clk_i = ~sys_clk_i;
    crsl_core i_dut (.sys_clk_i, .srst_i, .cmd_vld_i, .cmd_rdy_o, .cmd_i, .card_i, .xfer_done_i,
        .prg_done_i, .state_o, .app_o, .card_clk_i(card_clk), .cmd_o, .cmd_oe_o, .dat0_o,
        .dat0_oe_o);
    crsl_host_model i_host (.run_i(run), .clr_i(clr), .cmd_o_i(cmd_o), .cmd_oe_i(cmd_oe_o),
        .dat0_i(dat0_o), .dat0_oe_i(dat0_oe_o), .card_clk_o(card_clk), .frame_o(frame),
        .nbits_o(nbits), .busy_o(busy));
    // ==========================================================================
    // expected frames
    function automatic logic [6:0] crc7(input logic [39:0] d);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
        return c;
    endfunction
    function automatic logic [135:0] r1(input logic [39:0] h);
        return {88'h0, h, crc7(h), 1'b1};
    endfunction
    function automatic logic [135:0] r2(input logic [127:0] r);
        return {2'b00, 6'h3f, r[127:1], 1'b1};
    endfunction
    // ==========================================================================
    // shared tasks
    task check(input string what, input logic [135:0] got, input logic [135:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task rst;
        srst_i = 1;
        run = 1;
        repeat (20) @(negedge sys_clk_i);
        srst_i = 0;
        check("reset state", state_o, crsl_pkg::ST_IDLE);
    endtask
    task xact(input logic [5:0] idx, input logic rd, input logic vdd, input logic pb,
              input crsl_pkg::crsl_state_t st, input logic [135:0] exp, input logic [7:0] len);
        clr = 1;
        run = 1;
        @(negedge sys_clk_i);
        clr = 0;
        cmd_i = '{idx: idx, rd: rd, vdd_ok: vdd, pwr_busy: pb, addressed: 1'b1};
        cmd_vld_i = 1;
        @(negedge sys_clk_i);
        cmd_vld_i = 0;
        for (int k = 0; k < 3000 && cmd_rdy_o !== 1'b1; k++) @(negedge sys_clk_i);
        check("state", state_o, st);
        check("frame length", nbits, len);
        check("frame", frame, exp);
        run = 0;
    endtask
    task s1(input logic [5:0] idx, input crsl_pkg::crsl_state_t st);
        xact(idx, 0, 1, 0, st, r1({2'b00, idx, ST}), crsl_pkg::LEN_SHORT);
    endtask
    task pulse(input logic xfer);
        @(negedge sys_clk_i);
        if (xfer) xfer_done_i = 1;
        else prg_done_i = 1;
        @(negedge sys_clk_i);
        xfer_done_i = 0;
        prg_done_i = 0;
    endtask
    // ==========================================================================
    // scenarios
    task t_power_up(input logic vdd, input logic pb, input crsl_pkg::crsl_state_t st);
        s1(crsl_pkg::CMD_APP_PREFIX, crsl_pkg::ST_IDLE);
        check("app", app_o, 1'b1);
        xact(crsl_pkg::ACMD_OP_COND, 0, vdd, pb, st, vdd ? {88'h0, 2'b00, 6'h3f, card_i.ocr,
             7'h7f, 1'b1} : 136'h0, vdd ? crsl_pkg::LEN_SHORT : 8'h00);
        $display("done power up");
    endtask
    task t_identify;
        xact(crsl_pkg::CMD_ALL_ID, 0, 1, 0, crsl_pkg::ST_IDENT, r2(card_i.cid),
             crsl_pkg::LEN_LONG);
        xact(crsl_pkg::CMD_PUB_ADDR, 0, 1, 0, crsl_pkg::ST_STBY, r1({8'h03, 16'hbeef, ST[23],
             ST[22], ST[19], ST[12:0]}), crsl_pkg::LEN_SHORT);
        xact(crsl_pkg::CMD_SEND_SPEC, 0, 1, 0, crsl_pkg::ST_STBY, r2(card_i.csd),
             crsl_pkg::LEN_LONG);
        xact(crsl_pkg::CMD_SEND_ID, 0, 1, 0, crsl_pkg::ST_STBY, r2(card_i.cid),
             crsl_pkg::LEN_LONG);
        s1(crsl_pkg::CMD_SELECT, crsl_pkg::ST_TRAN);
        $display("done identify");
    endtask
    task t_erase_lock;
        s1(crsl_pkg::CMD_ERASE_START, crsl_pkg::ST_TRAN);
        s1(crsl_pkg::CMD_ERASE_END, crsl_pkg::ST_TRAN);
        s1(crsl_pkg::CMD_ERASE, crsl_pkg::ST_PRG);
        check("busy", busy, 1'b1);
        pulse(0);
        s1(crsl_pkg::CMD_STATUS, crsl_pkg::ST_TRAN);
        check("busy", busy, 1'b0);
        s1(crsl_pkg::CMD_LOCK, crsl_pkg::ST_RCV);
        pulse(1);
        s1(crsl_pkg::CMD_STATUS, crsl_pkg::ST_PRG);
        check("busy", busy, 1'b1);
        pulse(0);
        $display("done erase lock");
    endtask
    task t_app_tran;
        logic [5:0] ac[5] = '{crsl_pkg::ACMD_BUS_WIDTH, crsl_pkg::ACMD_STATUS,
            crsl_pkg::ACMD_WR_COUNT, crsl_pkg::ACMD_PRE_ERASE, crsl_pkg::ACMD_DETECT};
        foreach (ac[i]) begin
            s1(crsl_pkg::CMD_APP_PREFIX, crsl_pkg::ST_TRAN);
            s1(ac[i], crsl_pkg::ST_TRAN);
        end
        s1(crsl_pkg::CMD_APP_PREFIX, crsl_pkg::ST_TRAN);
        s1(crsl_pkg::ACMD_CONFIG, crsl_pkg::ST_DATA);
        pulse(1);
        xact(crsl_pkg::CMD_GEN, 1, 1, 0, crsl_pkg::ST_DATA, r1({8'h38, ST}),
             crsl_pkg::LEN_SHORT);
        pulse(1);
        s1(crsl_pkg::CMD_GEN, crsl_pkg::ST_RCV);
        $display("done app tran");
    endtask
    initial begin
        #300_000;
        n_fail++;
        test_done;
    end
    initial begin
        rst;
        t_power_up(1, 1, crsl_pkg::ST_IDLE);
        t_power_up(1, 0, crsl_pkg::ST_READY);
        t_identify;
        t_erase_lock;
        t_app_tran;
        rst;
        t_power_up(0, 0, crsl_pkg::ST_INA);
        test_done;
    end
endmodule
